// ### tb_top.sv
// testbench: port drive, change line, pulse width, scheduler and strap
`timescale 1ns/100ps
module tb_top;
    import tipa_pkg::*;
    logic mclk = 0, rst_n = 0, burst_done = 0, sda_o, sda_oe, cn_o, cn_oe, burst_req, scl, sda_low, nack;
    logic [6:0] io_o, io_oe, tb_in = 0, io_i;
    logic [5:0] key_present = 6'h03, key_detect = 0;
    logic [2:0] burst_chan, dn = 0;
    logic cal_b = 0, dif_b = 0;
    logic [7:0] rd_d;
    logic [31:0] seed = 32'h47be;
    int err_count = 0, samples_checked = 0, burst_cnt = 0, n;
    logic [2:0] exp_q[$];
    always #10 mclk = ~mclk;
    assign io_i = (io_oe & io_o) | (~io_oe & tb_in);
    tipa_host u_host (.scl(scl), .sda_low(sda_low), .nack(nack), .sda_oe(sda_oe));
    tipa_port #(.BASE_CYCLES_P(50)) u_dut (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(~(sda_low | sda_oe)),
        .sda_o(sda_o), .sda_oe(sda_oe), .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .change_notify_n_o(cn_o),
        .change_notify_n_oe(cn_oe), .key_present(key_present), .key_detect(key_detect), .cal_busy(cal_b),
        .consecutive_detect_filter_busy(dif_b), .burst_req(burst_req), .burst_chan(burst_chan),
        .burst_done(burst_done));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic step(input int c);
        repeat (c) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // sensing core stand-in: ends each burst three cycles later; notes one round of expected channels
    always @(posedge mclk) begin
        dn <= burst_req ? 3'h3 : (dn != 0 ? dn - 3'h1 : 3'h0);
        burst_done <= (dn == 3'h1);
        if (!rst_n) exp_q.delete();
        else if (exp_q.size() == 0) for (int k = 0; k < 6; k++) if (key_present[k]) exp_q.push_back(k[2:0]);
    end
    // watcher: each burst request takes the oldest note
    always @(posedge mclk) if (rst_n && burst_req) begin
        burst_cnt++;
        if (exp_q.size() > 0) chk(burst_chan === exp_q.pop_front(), "burst channel");
    end
    // watchdog: about 20k mclk cycles, nearly twice the expected run
    initial begin
        #400000;
        err_count++;
        report_and_stop;
    end
    initial begin
        step(1);
        seed = lfsr(seed);
        key_present = seed[5:0] | 6'h03;
        step(20);
        rst_n = 1;
        step(10);
        chk(io_oe === 7'h00, "lines not inputs");
        tb_in = seed[12:6] | 7'h01;
        step(10);
        chk(cn_oe === 1'b1, "no change flagged");
        // dropped write to the detect status leaves the pointer on input status
        u_host.wr(7'h2a, REG_DET_STAT, 8'h00);
        u_host.rd(7'h2a, rd_d);
        step(2);
        chk(rd_d === {1'b0, tb_in} && cn_oe === 1'b0, "status read or release");
        u_host.wr(7'h2a, REG_DIR, 8'h7f);
        u_host.wr(7'h2a, REG_DET_MSK, 8'h00);
        u_host.wr(7'h2a, REG_USER, 8'h05);
        step(5);
        chk(io_oe === 7'h7f && io_o === 7'h05, "digital drive");
        u_host.wr(7'h2a, REG_POL, 8'h00);
        step(5);
        chk(io_o === 7'h7a, "active low");
        u_host.wr(7'h2a, REG_POL, 8'h7f);
        key_detect = 6'h3f;
        u_host.wr(7'h2a, REG_DET_MSK, 8'h02);
        step(150);
        chk(io_o[1] === 1'b1, "detect drive");
        u_host.wr(7'h2a, REG_PWM_LVL, 8'h80);
        u_host.wr(7'h2a, REG_PWM_MSK, 8'h01);
        n = 0;
        for (int i = 0; i < 256; i++) begin
            step(1);
            n += (io_o[0] === 1'b1);
        end
        chk(n == 128, "pulse width duty");
        u_host.wr(7'h2b, REG_DIR, 8'h00);
        chk(nack === 1'b1 && io_oe === 7'h7f, "foreign address taken");
        u_host.wr(7'h2a, REG_INTV, 8'h00);
        step(50);
        n = burst_cnt;
        step(300);
        chk(burst_cnt == n && io_o[1] === 1'b1, "activity in sleep");
        // filter busy, then calibration busy, must wake the sleeping scheduler
        for (int j = 0; j < 2; j++) begin
            n = burst_cnt;
            {cal_b, dif_b} = 2'(j + 1);
            step(120);
            chk(burst_cnt > n, "busy did not force interval one");
        end
        {cal_b, dif_b} = 2'h0;
        u_host.wr(7'h2a, REG_INTV, 8'hff);
        n = burst_cnt;
        step(400);
        chk(burst_cnt - n > 56, "free run too slow");
        u_host.sda_low = 1'b1;
        rst_n = 0;
        step(20);
        rst_n = 1;
        step(10);
        chk(io_oe === DIR_STANDALONE, "standalone direction");
        step(100);
        chk(io_o === {1'b0, key_present}, "standalone detect report");
        report_and_stop;
    end
endmodule

// ### tipa_host.sv
// host model: serial master on its own 80 ns clock, open-drain data line
`timescale 1ns/100ps
module tipa_host (
    output logic      scl,
    output logic      sda_low,
    output logic      nack,
    input  wire logic sda_oe
);
    logic lclk;
    // link clock, phase apart from mclk
    initial begin
        lclk = 1'b0;
        scl = 1'b1;
        sda_low = 1'b0;
        nack = 1'b0;
        #7;
        forever #40 lclk = ~lclk;
    end
    // a half bit, kept well above the slave's minimum high and low times
    task automatic tk;
        repeat (3) @(posedge lclk);
    endtask
    // write frame: address, pointer, data, each followed by an acknowledge slot
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
        logic [26:0] s;
        s = {a, 1'b0, 1'b1, r, 1'b1, d, 1'b1};
        nack = 1'b0;
        sda_low = 1'b1;
        tk;
        for (int i = 26; i >= 0; i--) begin
            scl = 1'b0;
            sda_low = ~s[i];
            tk;
            scl = 1'b1;
            tk;
            if (i % 9 == 0 && sda_oe !== 1'b1) nack = 1'b1;
        end
        stop_bus;
    endtask
    // read frame: address with read bit, one byte in, no-acknowledge to end it
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic [17:0] s;
        s = {a, 1'b1, 1'b1, 8'hff, 1'b1};
        nack = 1'b0;
        sda_low = 1'b1;
        tk;
        for (int i = 17; i >= 0; i--) begin
            scl = 1'b0;
            sda_low = ~s[i];
            tk;
            scl = 1'b1;
            tk;
            if (i == 9 && sda_oe !== 1'b1) nack = 1'b1;
            if (i > 0 && i < 9) d = {d[6:0], ~sda_oe};
        end
        stop_bus;
    endtask
    // stop condition: data rises while the clock is high
    task automatic stop_bus;
        scl = 1'b0;
        sda_low = 1'b1;
        tk;
        scl = 1'b1;
        tk;
        sda_low = 1'b0;
        tk;
    endtask
endmodule

// ### tipa_pkg.sv
// package: register map, reset values, timing and types of the touch I/O port
package tipa_pkg;
    localparam int         NUM_LINES      = 7;
    localparam int         NUM_KEYS       = 6;
    // register offsets on the serial slave
    localparam logic [7:0] REG_DET_STAT   = 8'h04;
    localparam logic [7:0] REG_IN_STAT    = 8'h05;
    localparam logic [7:0] REG_DIR        = 8'h17;
    localparam logic [7:0] REG_PWM_MSK    = 8'h18;
    localparam logic [7:0] REG_DET_MSK    = 8'h19;
    localparam logic [7:0] REG_POL        = 8'h1a;
    localparam logic [7:0] REG_USER       = 8'h1b;
    localparam logic [7:0] REG_PWM_LVL    = 8'h1c;
    localparam logic [7:0] REG_INTV       = 8'h1d;
    // values after reset
    localparam logic [6:0] DIR_RESET      = 7'h00;
    localparam logic [6:0] DIR_STANDALONE = 7'h7f;
    localparam logic [6:0] MASK_RESET     = 7'h00;
    // detection routed to every line by default, so standalone lines report keys
    localparam logic [6:0] DET_MSK_RESET  = 7'h7f;
    localparam logic [6:0] POL_RESET      = 7'h7f;
    localparam logic [7:0] PWM_LVL_RESET  = 8'h00;
    localparam logic [7:0] INTV_RESET     = 8'h01;
    // interval codes
    localparam logic [7:0] INTV_SLEEP     = 8'h00;
    localparam logic [7:0] INTV_ONE       = 8'h01;
    localparam logic [7:0] INTV_FREE      = 8'hff;
    // timing
    localparam int         BASE_CYCLE_NS  = 16000000;
    localparam int         MCLK_PERIOD_NS = 20;
    localparam int         BASE_CYCLES    = BASE_CYCLE_NS / MCLK_PERIOD_NS;
    localparam logic [1:0] STRAP_WAIT     = 2'h3;
    localparam logic [3:0] BYTE_BITS      = 4'h8;

    typedef struct packed {
        logic [6:0] dir;
        logic [6:0] pwm_msk;
        logic [6:0] det_msk;
        logic [6:0] pol;
        logic [6:0] user;
        logic [7:0] pwm_lvl;
        logic [7:0] intv;
    } tipa_cfg_t;

    typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_ACK, BUS_WR, BUS_RD, BUS_RACK} tipa_bus_st_t;
    typedef enum logic {ACQ_IDLE, ACQ_BURST} tipa_acq_st_t;
endpackage

// ### tipa_port.sv
// touch I/O port: serial slave, configuration, output drive, change line and acquisition scheduler
`timescale 1ns/100ps

// Notes on behaviour
// - two to six keys; keys not present are skipped in the burst sequence
// - sda low and scl high at power-up selects standalone, no serial slave
// - standalone keeps defaults but loads direction mask with 7f
// - seven lines each input or output; all inputs after normal power-up
// - one 8-bit pulse-width level, 256 values, shared by all pulse-width lines
// - direction bit set makes output; clear makes input, other masks ignored
// - input levels mirrored in input status; any change asserts change line
// - pulse-width mask bit selects waveform on an output line, else digital
// - pulse-width level lives in its own host-writable register
// - detect mask bit ties output to key detection, else user buffer drives
// - polarity bit set gives active high output, clear gives active low
// - base cycle about 16 ms; setting N gives one acquisition per N cycles
// - setting zero sleeps, no acquisitions, detect status held, input status still follows pins
// - setting 255 runs acquisitions back to back
// - calibration or detect filtering forces an interval of one base cycle
// - change line active low open drain, released when status is read
module tipa_port
    import tipa_pkg::*;
#(
    parameter int         BASE_CYCLES_P = BASE_CYCLES,
    parameter logic [6:0] SLAVE_ADDR    = 7'h2a  // arbitrary bus address
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [6:0] io_i,
    output logic      [6:0] io_o,
    output logic      [6:0] io_oe,
    output logic            change_notify_n_o,
    output logic            change_notify_n_oe,
    input  wire logic [5:0] key_present,
    input  wire logic [5:0] key_detect,
    input  wire logic       cal_busy,
    input  wire logic       consecutive_detect_filter_busy,
    output logic            burst_req,
    output logic      [2:0] burst_chan,
    input  wire logic       burst_done
);
    // ------------------------------------------------------------
    // pin synchronisers and link-clock shifter
    // ------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [6:0] io_sync1_r;
    logic [6:0] io_sync2_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic [7:0] link_shift_r;
    logic       scl_s;
    logic       sda_s;

    // two flops on every pin before mclk logic uses it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            io_sync1_r <= 7'h00;
            io_sync2_r <= 7'h00;
            scl_q_r    <= 1'b1;
            sda_q_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            io_sync1_r <= io_i;
            io_sync2_r <= io_sync1_r;
            scl_q_r    <= scl_sync_r[1];
            sda_q_r    <= sda_sync_r[1];
        end
    end
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];

    // data bits shift in on the link's own clock; read only while scl is low
    always_ff @(posedge scl_i) begin
        link_shift_r <= {link_shift_r[6:0], sda_i};
    end

    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;
    assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;

    // ------------------------------------------------------------
    // power-up strap
    // ------------------------------------------------------------
    logic [1:0] strap_cnt_r;
    logic       strap_done_r;
    logic       standalone_r;
    logic       strap_take;
    assign strap_take = ~strap_done_r & (strap_cnt_r == STRAP_WAIT);

    // strap pins are caught once the synchronisers hold real levels
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
            standalone_r <= 1'b0;
        end else if (strap_take) begin
            strap_done_r <= 1'b1;
            standalone_r <= ~sda_s & scl_s;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    tipa_bus_st_t bus_st_r;
    tipa_cfg_t    cfg_r;
    logic [3:0]   bit_cnt_r;
    logic [7:0]   ptr_r;
    logic [7:0]   wr_addr_r;
    logic [7:0]   wr_data_r;
    logic [7:0]   tx_r;
    logic         ptr_set_r;
    logic         rd_dir_r;
    logic         acked_r;
    logic         wr_en_r;
    logic         rd_clr_r;
    logic         sda_oe_r;
    logic         od_low_r;
    logic [7:0]   rd_mux;
    logic [5:0]   det_status_r;
    logic [6:0]   in_status_r;
    logic         rd_is_stat;

    // read data for the current pointer
    always_comb begin
        unique case (ptr_r)
            REG_DET_STAT: rd_mux = {2'h0, det_status_r};
            REG_IN_STAT:  rd_mux = {1'h0, in_status_r};
            REG_DIR:      rd_mux = {1'h0, cfg_r.dir};
            REG_PWM_MSK:  rd_mux = {1'h0, cfg_r.pwm_msk};
            REG_DET_MSK:  rd_mux = {1'h0, cfg_r.det_msk};
            REG_POL:      rd_mux = {1'h0, cfg_r.pol};
            REG_USER:     rd_mux = {1'h0, cfg_r.user};
            REG_PWM_LVL:  rd_mux = cfg_r.pwm_lvl;
            REG_INTV:     rd_mux = cfg_r.intv;
            default:      rd_mux = 8'h00;
        endcase
    end
    assign rd_is_stat = (ptr_r == REG_DET_STAT) | (ptr_r == REG_IN_STAT);

    // byte engine: address, pointer, writes with ack, reads with auto-increment
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_st_r  <= BUS_IDLE;
            bit_cnt_r <= 4'h0;
            ptr_r     <= 8'h00;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            tx_r      <= 8'h00;
            ptr_set_r <= 1'b0;
            rd_dir_r  <= 1'b0;
            acked_r   <= 1'b0;
            wr_en_r   <= 1'b0;
            rd_clr_r  <= 1'b0;
            sda_oe_r  <= 1'b0;
        end else begin
            wr_en_r  <= 1'b0;
            rd_clr_r <= 1'b0;
            if (standalone_r || !strap_done_r) begin
                bus_st_r <= BUS_IDLE;
                sda_oe_r <= 1'b0;
            end else if (bus_start) begin
                bus_st_r  <= BUS_ADDR;
                bit_cnt_r <= 4'h0;
                ptr_set_r <= 1'b0;
                sda_oe_r  <= 1'b0;
            end else if (bus_stop) begin
                bus_st_r <= BUS_IDLE;
                sda_oe_r <= 1'b0;
            end else if (scl_rise) begin
                if (bus_st_r == BUS_ADDR || bus_st_r == BUS_WR || bus_st_r == BUS_RD) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                if (bus_st_r == BUS_RACK) begin
                    acked_r <= ~sda_s;
                end
            end else if (scl_fall) begin
                unique case (bus_st_r)
                    BUS_IDLE: begin
                    end
                    BUS_ADDR: begin
                        if (bit_cnt_r == BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            if (link_shift_r[7:1] == SLAVE_ADDR) begin
                                sda_oe_r <= 1'b1;
                                rd_dir_r <= link_shift_r[0];
                                bus_st_r <= BUS_ACK;
                            end else begin
                                bus_st_r <= BUS_IDLE;
                            end
                        end
                    end
                    BUS_WR: begin
                        if (bit_cnt_r == BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe_r  <= 1'b1;
                            bus_st_r  <= BUS_ACK;
                            if (!ptr_set_r) begin
                                ptr_r     <= link_shift_r;
                                ptr_set_r <= 1'b1;
                            end else begin
                                wr_en_r   <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= link_shift_r;
                                ptr_r     <= ptr_r + 8'h01;
                            end
                        end
                    end
                    BUS_ACK, BUS_RACK: begin
                        if (bus_st_r == BUS_ACK && !rd_dir_r) begin
                            sda_oe_r <= 1'b0;
                            bus_st_r <= BUS_WR;
                        end else if (bus_st_r == BUS_ACK || acked_r) begin
                            tx_r     <= {rd_mux[6:0], 1'b0};
                            sda_oe_r <= ~rd_mux[7];
                            rd_clr_r <= rd_is_stat;
                            bus_st_r <= BUS_RD;
                        end else begin
                            sda_oe_r <= 1'b0;
                            bus_st_r <= BUS_IDLE;
                        end
                    end
                    BUS_RD: begin
                        if (bit_cnt_r == BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe_r  <= 1'b0;
                            ptr_r     <= ptr_r + 8'h01;
                            bus_st_r  <= BUS_RACK;
                        end else begin
                            sda_oe_r <= ~tx_r[7];
                            tx_r     <= {tx_r[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_r.dir     <= DIR_RESET;
            cfg_r.pwm_msk <= MASK_RESET;
            cfg_r.det_msk <= DET_MSK_RESET;
            cfg_r.pol     <= POL_RESET;
            cfg_r.user    <= MASK_RESET;
            cfg_r.pwm_lvl <= PWM_LVL_RESET;
            cfg_r.intv    <= INTV_RESET;
        end else if (strap_take && !sda_s && scl_s) begin
            cfg_r.dir <= DIR_STANDALONE;
        end else if (wr_en_r) begin
            unique case (wr_addr_r)
                REG_DIR:     cfg_r.dir     <= wr_data_r[6:0];
                REG_PWM_MSK: cfg_r.pwm_msk <= wr_data_r[6:0];
                REG_DET_MSK: cfg_r.det_msk <= wr_data_r[6:0];
                REG_POL:     cfg_r.pol     <= wr_data_r[6:0];
                REG_USER:    cfg_r.user    <= wr_data_r[6:0];
                REG_PWM_LVL: cfg_r.pwm_lvl <= wr_data_r;
                REG_INTV:    cfg_r.intv    <= wr_data_r;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // acquisition scheduler and burst sequencer
    // ------------------------------------------------------------
    tipa_acq_st_t acq_st_r;
    logic [19:0]  base_cnt_r;
    logic [7:0]   intv_cnt_r;
    logic         go_pend_r;
    logic         acq_done_r;
    logic         burst_req_r;
    logic [2:0]   burst_chan_r;
    logic [7:0]   eff_intv;
    logic         base_tick;
    logic         acq_go;
    logic         found;
    logic [2:0]   next_ch;
    logic [2:0]   search_from;

    assign eff_intv  = (cal_busy | consecutive_detect_filter_busy) ? INTV_ONE : cfg_r.intv;
    assign base_tick = (base_cnt_r == 20'(BASE_CYCLES_P - 1));
    // a start still pending when sleep is selected is dropped, not run
    assign acq_go    = (acq_st_r == ACQ_IDLE)
                     & ((eff_intv == INTV_FREE) | (go_pend_r & (eff_intv != INTV_SLEEP)));

    // base cycle counter and interval divider
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            base_cnt_r <= 20'h00000;
            intv_cnt_r <= 8'h00;
            go_pend_r  <= 1'b0;
        end else begin
            base_cnt_r <= base_tick ? 20'h00000 : base_cnt_r + 20'h00001;
            if (eff_intv == INTV_SLEEP || eff_intv == INTV_FREE) begin
                go_pend_r <= 1'b0;
            end else if (base_tick) begin
                if ({1'b0, intv_cnt_r} + 9'h001 >= {1'b0, eff_intv}) begin
                    intv_cnt_r <= 8'h00;
                    go_pend_r  <= 1'b1;
                end else begin
                    intv_cnt_r <= intv_cnt_r + 8'h01;
                end
            end else if (acq_go) begin
                go_pend_r <= 1'b0;
            end
        end
    end

    // lowest present key at or above the search point
    assign search_from = (acq_st_r == ACQ_IDLE) ? 3'h0 : burst_chan_r + 3'h1;
    always_comb begin
        found   = 1'b0;
        next_ch = 3'h0;
        for (int k = NUM_KEYS - 1; k >= 0; k--) begin
            if (key_present[k] && 3'(k) >= search_from) begin
                found   = 1'b1;
                next_ch = 3'(k);
            end
        end
    end

    // one burst per present key, then latch detection
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acq_st_r     <= ACQ_IDLE;
            burst_req_r  <= 1'b0;
            burst_chan_r <= 3'h0;
            acq_done_r   <= 1'b0;
        end else begin
            burst_req_r <= 1'b0;
            acq_done_r  <= 1'b0;
            unique case (acq_st_r)
                ACQ_IDLE: begin
                    if (acq_go && found) begin
                        burst_req_r  <= 1'b1;
                        burst_chan_r <= next_ch;
                        acq_st_r     <= ACQ_BURST;
                    end else if (acq_go) begin
                        acq_done_r <= 1'b1;
                    end
                end
                ACQ_BURST: begin
                    if (burst_done && found) begin
                        burst_req_r  <= 1'b1;
                        burst_chan_r <= next_ch;
                    end else if (burst_done) begin
                        acq_st_r   <= ACQ_IDLE;
                        acq_done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status, change line and output drive
    // ------------------------------------------------------------
    logic [6:0] in_status_nxt;
    logic [5:0] det_status_nxt;
    logic       chg_event;
    logic       chg_r;
    logic [7:0] pwm_cnt_r;
    logic       pwm_on;
    logic [6:0] line_src;
    logic [6:0] line_gated;
    logic [6:0] io_o_r;
    logic [6:0] io_oe_r;

    assign in_status_nxt  = io_sync2_r & ~cfg_r.dir;
    assign det_status_nxt = acq_done_r ? (key_detect & key_present) : det_status_r;
    assign chg_event      = (in_status_nxt != in_status_r) | (det_status_nxt != det_status_r);

    // detect status only moves at acquisition end, so sleep holds it; input status follows the pins every cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_status_r  <= 7'h00;
            det_status_r <= 6'h00;
            chg_r        <= 1'b0;
            od_low_r     <= 1'b0;
        end else begin
            in_status_r  <= in_status_nxt;
            det_status_r <= det_status_nxt;
            if (chg_event) begin
                chg_r <= 1'b1;
            end else if (rd_clr_r) begin
                chg_r <= 1'b0;
            end
        end
    end

    // free-running 256-step pulse-width counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwm_cnt_r <= 8'h00;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
        end
    end
    assign pwm_on = (pwm_cnt_r < cfg_r.pwm_lvl);

    // source, then gate, then polarity
    assign line_src   = (cfg_r.det_msk & {1'b0, det_status_r}) | (~cfg_r.det_msk & cfg_r.user);
    assign line_gated = line_src & (~cfg_r.pwm_msk | {NUM_LINES{pwm_on}});

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            io_o_r  <= 7'h00;
            io_oe_r <= 7'h00;
        end else begin
            io_o_r  <= cfg_r.pol & line_gated | ~cfg_r.pol & ~line_gated;
            io_oe_r <= cfg_r.dir;
        end
    end

    assign io_o               = io_o_r;
    assign io_oe              = io_oe_r;
    assign sda_o              = od_low_r;
    assign sda_oe             = sda_oe_r;
    assign change_notify_n_o  = od_low_r;
    assign change_notify_n_oe = chg_r;
    assign burst_req          = burst_req_r;
    assign burst_chan         = burst_chan_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    oe_follow_a: assert property (##1 io_oe == $past(cfg_r.dir)) else $error("oe not following dir");
    strap_load_a: assert property ($rose(standalone_r) |-> cfg_r.dir == 7'h7f) else $error("standalone dir");
    strap_quiet_a: assert property (standalone_r |-> !sda_oe) else $error("bus active in standalone");
    skip_key_a: assert property (burst_req |-> key_present[burst_chan]) else $error("absent key burst");
    chg_set_a: assert property (in_status_nxt != in_status_r |=> change_notify_n_oe) else $error("chg not set");
    chg_clear_a: assert property (rd_clr_r && !chg_event |=> !change_notify_n_oe) else $error("chg stuck");
    sleep_hold_a: assert property (eff_intv == 8'h00 && acq_st_r == ACQ_IDLE && !acq_done_r |=> !burst_req && $stable(det_status_r)) else $error("sleep acq");
    free_run_a: assert property (acq_done_r && eff_intv == 8'hff && acq_st_r == ACQ_IDLE |-> acq_go) else $error("free run gap");
    fast_intv_a: assert property (cal_busy || consecutive_detect_filter_busy |-> eff_intv == 8'h01) else $error("interval not forced");
    pwm_zero_a: assert property (cfg_r.pwm_lvl == 8'h00 |-> !pwm_on) else $error("pwm on at zero");
    det_drive_a: assert property (##2 $past(cfg_r.det_msk[1] & ~cfg_r.pwm_msk[1] & cfg_r.pol[1])
        |-> io_o[1] == $past(det_status_r[1])) else $error("detect drive");
    pol_low_a: assert property (##2 $past(~cfg_r.det_msk[1] & ~cfg_r.pwm_msk[1] & ~cfg_r.pol[1])
        |-> io_o[1] == $past(~cfg_r.user[1])) else $error("active low drive");

    acq_cov_c: cover property (burst_req ##[1:50] acq_done_r);
    wr_cov_c: cover property (wr_en_r && wr_addr_r == REG_DIR);
    rd_cov_c: cover property (rd_clr_r);
    chg_cov_c: cover property ($rose(change_notify_n_oe));
endmodule
